// ---- shared/ext_bus_defs.vh ----
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH

// ********************************************************************
// Register indices and byte addresses (byte address = 4 * index)
// ********************************************************************
`define WAIT_STATE_COUNTS_IDX   8'h28
`define BANK_SWITCH_CONTROL_IDX 8'h29
`define WAIT_STATE_CONFIG_IDX   8'h2B
`define BUS_STATUS_IDX          8'h2C
`define WAIT_STATE_COUNTS_ADDR   12'h0A0
`define BANK_SWITCH_CONTROL_ADDR 12'h0A4
`define WAIT_STATE_CONFIG_ADDR   12'h0AC
`define BUS_STATUS_ADDR          12'h0B0

// ********************************************************************
// Reset values and writable masks
// ********************************************************************
`define WAIT_STATE_COUNTS_RST    16'h7FFF
`define BANK_SWITCH_CONTROL_RST  16'hF800
`define WAIT_STATE_CONFIG_RST    16'h0000
`define BANK_SWITCH_CONTROL_MASK 16'hF807
`define WAIT_STATE_CONFIG_MASK   16'h0001

// ********************************************************************
// Field positions
// ********************************************************************
`define EXTENDED_PROGRAM_RANGE_BIT 15
`define IO_FIELD_LSB               12
`define DATA_HIGH_FIELD_LSB        9
`define DATA_LOW_FIELD_LSB         6
`define PROG_HIGH_FIELD_LSB        3
`define PROG_LOW_FIELD_LSB         0
`define WAIT_MULTIPLIER_BIT        0
`define BANK_COMPARE_MSB           15
`define BANK_COMPARE_LSB           12
`define PROGRAM_DATA_READ_GAP_BIT  11
`define HOST_PORT_BUS_KEEPER_BIT   2
`define DATA_BUS_KEEPER_BIT        1
`define EXTERNAL_BUS_OFF_BIT       0

// ********************************************************************
// Access spaces and limits
// ********************************************************************
`define SPACE_PROGRAM 2'h0
`define SPACE_DATA    2'h1
`define SPACE_IO      2'h2
`define MAX_WAIT_STATES 4'hE

`endif

// ---- rtl/wait_select.v ----
`include "ext_bus_defs.vh"

// Picks the base wait field for one access and applies the multiplier.
module wait_select
(
    input  wire [15:0] wait_counts,   // Wait-state count register.
    input  wire        multiplier,    // Doubling bit.
    input  wire [1:0]  space,         // Access space.
    input  wire        addr_high,     // Address bit 15 of the access.
    output wire [3:0]  wait_total     // Final number of wait cycles.
);
    reg [2:0] base;                   // Selected base count.

    // ****************************************************************
    // Range decode
    // ****************************************************************
    // A three-way decode on the space, then the half of the page.
    always @*
    begin
        base = 3'h0;
        case (space)
            `SPACE_IO:
                base = wait_counts[`IO_FIELD_LSB +: 3];
            `SPACE_DATA:
                if (addr_high)
                    base = wait_counts[`DATA_HIGH_FIELD_LSB +: 3];
                else
                    base = wait_counts[`DATA_LOW_FIELD_LSB +: 3];
            default:
                if (!wait_counts[`EXTENDED_PROGRAM_RANGE_BIT] && addr_high)
                    base = wait_counts[`PROG_HIGH_FIELD_LSB +: 3];
                else
                    base = wait_counts[`PROG_LOW_FIELD_LSB +: 3];
        endcase
    end

    // Doubling by a shift gives at most fourteen, so no clamp is needed.
    assign wait_total = multiplier ? {base, 1'b0} : {1'b0, base};
endmodule // wait_select

// ---- rtl/wait_counter.v ----
// Down counter for wait cycles with a clock-enable that stands in for a gated clock.
module wait_counter
#(
    parameter W = 4                   // Counter width.
)
(
    input  wire         pclk,         // Clock.
    input  wire         presetn,      // Asynchronous reset, active low.
    input  wire         clk_en,       // Counter clock enable.
    input  wire         load,         // Load a new count.
    input  wire [W-1:0] load_val,     // Count to load.
    output wire         zero          // Count is zero.
);
    reg [W-1:0] count_q;              // Remaining wait cycles.

    // ****************************************************************
    // Counter
    // ****************************************************************
    // With the enable low nothing toggles, which is what saves power.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= {W{1'b0}};
        else if (clk_en)
        begin
            if (load)
                count_q <= load_val;
            else if (count_q != {W{1'b0}})
                count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign zero = (count_q == {W{1'b0}});
endmodule // wait_counter

// ---- rtl/ext_bus_wait_state_bank_switch.v ----
// Local design decision: the APB interface to the registers.
`include "ext_bus_defs.vh"

module ext_bus_wait_state_bank_switch
(
    input  wire        pclk,             // Machine clock.
    input  wire        presetn,          // Asynchronous reset, active low.
    input  wire        psel,             // APB select.
    input  wire        penable,          // APB enable.
    input  wire        pwrite,           // APB direction.
    input  wire [11:0] paddr,            // APB byte address.
    input  wire [31:0] pwdata,           // APB write data.
    output reg  [31:0] prdata,           // APB read data.
    output reg         pready,           // APB ready.
    output reg         pslverr,          // APB error for unmapped addresses.
    input  wire        acc_req,          // Core access request, taken while idle.
    input  wire [1:0]  acc_space,        // Program, data or I/O.
    input  wire        acc_read,         // High for a read.
    input  wire [22:0] acc_addr,         // Access address.
    input  wire [15:0] acc_wdata,        // Write data.
    output reg         acc_idle_q,       // Ready to take a request.
    output reg         acc_done_q,       // One-cycle pulse at completion.
    output reg  [15:0] acc_rdata_q,      // Read data of the last read.
    output reg  [22:0] ext_addr_q,       // External address bus.
    output reg         ext_prog_sel_n_q, // Program space select, active low.
    output reg         ext_data_sel_n_q, // Data space select, active low.
    output reg         ext_io_sel_n_q,   // I/O space select, active low.
    output reg         ext_strobe_n_q,   // Access strobe, active low.
    output reg         ext_read_q,       // High for read cycles.
    output reg  [15:0] ext_data_out_q,   // Data bus output.
    output reg         ext_data_oe_q,    // Data bus output enable.
    input  wire [15:0] ext_data_in,      // Data bus input.
    input  wire        ext_ready,        // Hardware ready, high when done.
    output reg  [15:0] data_keep_q,      // Level the data keeper holds.
    output reg         data_keep_oe_q,   // Data keeper drives the bus.
    output reg         host_keep_en_q,   // Host-port keeper enable.
    output reg         mode_lock_q       // Mode lock flag, set one cycle after bus-off takes effect.
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_IDLE   = 2'h0;   // Waiting for a request.
    localparam [1:0] ST_GAP    = 2'h1;   // Extra bank-switch cycle.
    localparam [1:0] ST_ACCESS = 2'h2;   // Strobe active, waits running.

    reg [1:0]  state_q;                  // Sequencer state.
    reg [15:0] wait_counts_q;            // Base wait counts.
    reg [15:0] bank_ctrl_q;              // Bank-switch control.
    reg [15:0] wait_cfg_q;               // Multiplier config.
    reg        bus_off_q;                // Bus-off has taken effect.
    reg [1:0]  cur_space_q;              // Space of access in progress.
    reg        cur_read_q;               // Direction of access in progress.
    reg [22:0] cur_addr_q;               // Address of access in progress.
    reg [15:0] cur_wdata_q;              // Write data of access in progress.
    reg [3:0]  cur_waits_q;              // Wait count of access in progress.
    reg        prev_valid_q;             // A previous access exists.
    reg [1:0]  prev_space_q;             // Space of previous access.
    reg        prev_read_q;              // Direction of previous access.
    reg [3:0]  prev_bank_q;              // Masked bank of previous access.
    reg [15:0] last_level_q;             // Last level seen on the data bus.

    wire [3:0] req_waits;                // Waits for the new request.
    wire       cnt_zero;                 // Wait counter has expired.
    wire       gen_active;               // Some range needs waits.
    wire [3:0] bank_mask;                // Bank compare mask.
    wire [3:0] req_bank;                 // Masked bank of the new request.
    wire       take_req;                 // New request accepted this cycle.
    wire       need_gap;                 // New request needs an extra cycle.
    wire       load_cnt;                 // Load the wait counter.
    wire       finish;                   // Access completes this cycle.
    wire       apb_setup;                // APB setup phase.
    wire       apb_write;                // APB write takes effect.
    wire       addr_hit;                 // APB address is mapped.
    wire [15:0] status;                  // Own status word.

    // ****************************************************************
    // Wait decode and counter
    // ****************************************************************
    wait_select u_select
    (
        .wait_counts (wait_counts_q),
        .multiplier  (wait_cfg_q[`WAIT_MULTIPLIER_BIT]),
        .space       (acc_space),
        .addr_high   (acc_addr[15]),
        .wait_total  (req_waits)
    );

    // The counter only runs while some field is nonzero or a count is left;
    // once everything is zero there is nothing to count and its clock stays still.
    assign gen_active = (wait_counts_q[14:0] != 15'h0000);

    wait_counter #(.W(4)) u_counter
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (gen_active || !cnt_zero),
        .load     (load_cnt),
        .load_val (cur_waits_q),
        .zero     (cnt_zero)
    );

    // ****************************************************************
    // Bank switch decision
    // ****************************************************************
    assign bank_mask = bank_ctrl_q[`BANK_COMPARE_MSB:`BANK_COMPARE_LSB];
    assign req_bank  = acc_addr[15:12] & bank_mask;
    assign take_req  = state_q == ST_IDLE && acc_req && !bus_off_q && !bank_ctrl_q[`EXTERNAL_BUS_OFF_BIT];

    // The first access after reset has no predecessor and gets no gap.
    assign need_gap = prev_valid_q &&
        (((acc_space == prev_space_q) && (acc_space != `SPACE_IO) && (req_bank != prev_bank_q))
        || ((prev_space_q == `SPACE_DATA) && (acc_space == `SPACE_PROGRAM))
        || (bank_ctrl_q[`PROGRAM_DATA_READ_GAP_BIT] && prev_read_q && acc_read &&
            (((prev_space_q == `SPACE_DATA) && (acc_space == `SPACE_PROGRAM)) ||
             ((prev_space_q == `SPACE_PROGRAM) && (acc_space == `SPACE_DATA)))));

    // The counter is loaded at the edge that drops the strobe, from the count captured at take.
    assign load_cnt = (state_q == ST_ACCESS) && ext_strobe_n_q;
    // Ready is only looked at once the strobe is out and the software waits have run out.
    assign finish   = (state_q == ST_ACCESS) && !ext_strobe_n_q && cnt_zero && ext_ready;

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    // Captures the request, inserts the gap cycle, then holds the strobe
    // through the waits and any ready extension.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q      <= ST_IDLE;
            cur_space_q  <= `SPACE_PROGRAM;
            cur_read_q   <= 1'b1;
            cur_addr_q   <= 23'h000000;
            cur_wdata_q  <= 16'h0000;
            cur_waits_q  <= 4'h0;
            prev_valid_q <= 1'b0;
            prev_space_q <= `SPACE_PROGRAM;
            prev_read_q  <= 1'b0;
            prev_bank_q  <= 4'h0;
            acc_done_q   <= 1'b0;
            acc_rdata_q  <= 16'h0000;
        end
        else
        begin
            acc_done_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                    if (take_req)
                    begin
                        cur_space_q  <= acc_space;
                        cur_read_q   <= acc_read;
                        cur_addr_q   <= acc_addr;
                        cur_wdata_q  <= acc_wdata;
                        cur_waits_q  <= req_waits;
                        prev_valid_q <= 1'b1;
                        prev_space_q <= acc_space;
                        prev_read_q  <= acc_read;
                        prev_bank_q  <= req_bank;
                        if (need_gap)
                            state_q <= ST_GAP;
                        else
                            state_q <= ST_ACCESS;
                    end
                ST_GAP:
                    state_q <= ST_ACCESS;
                ST_ACCESS:
                    if (finish)
                    begin
                        state_q    <= ST_IDLE;
                        acc_done_q <= 1'b1;
                        if (cur_read_q)
                            acc_rdata_q <= ext_data_in;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // The strobe cycle itself is the first access cycle and the waits follow
    // it, so an access with W waits keeps the strobe low for W + 1 cycles.
    // Loading from cur_waits_q, not from the decoder, keeps the count tied
    // to the request that was captured even if the request pins move on.

    // ****************************************************************
    // External pins
    // ****************************************************************
    // All pins leave flip-flops; with bus-off in effect every control goes
    // to its inactive level and the data driver is released.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_addr_q       <= 23'h000000;
            ext_prog_sel_n_q <= 1'b1;
            ext_data_sel_n_q <= 1'b1;
            ext_io_sel_n_q   <= 1'b1;
            ext_strobe_n_q   <= 1'b1;
            ext_read_q       <= 1'b1;
            ext_data_out_q   <= 16'h0000;
            ext_data_oe_q    <= 1'b0;
            last_level_q     <= 16'h0000;
        end
        else if (state_q == ST_ACCESS && !finish)
        begin
            ext_addr_q       <= cur_addr_q;
            ext_prog_sel_n_q <= cur_space_q != `SPACE_PROGRAM;
            ext_data_sel_n_q <= cur_space_q != `SPACE_DATA;
            ext_io_sel_n_q   <= cur_space_q != `SPACE_IO;
            ext_strobe_n_q   <= 1'b0;
            ext_read_q       <= cur_read_q;
            ext_data_out_q   <= cur_wdata_q;
            ext_data_oe_q    <= !cur_read_q;
            if (!cur_read_q)
                last_level_q <= cur_wdata_q;
        end
        else
        begin
            if (bus_off_q)
                ext_addr_q <= 23'h000000;
            ext_prog_sel_n_q <= 1'b1;
            ext_data_sel_n_q <= 1'b1;
            ext_io_sel_n_q   <= 1'b1;
            ext_strobe_n_q   <= 1'b1;
            ext_read_q       <= 1'b1;
            ext_data_oe_q    <= 1'b0;
            if (finish && cur_read_q)
                last_level_q <= ext_data_in;
        end
    end

    // ****************************************************************
    // Bus keepers, bus-off and mode lock
    // ****************************************************************
    // The keeper drives whenever enabled except during our own writes, reads included; it never fights our
    // own write driver because it takes the inverse of the output enable.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_keep_q    <= 16'h0000;
            data_keep_oe_q <= 1'b0;
            host_keep_en_q <= 1'b0;
            bus_off_q      <= 1'b0;
            mode_lock_q    <= 1'b0;
        end
        else
        begin
            data_keep_q    <= last_level_q;
            data_keep_oe_q <= bank_ctrl_q[`DATA_BUS_KEEPER_BIT] &&
                              !(state_q == ST_ACCESS && !finish && !cur_read_q);
            host_keep_en_q <= bank_ctrl_q[`HOST_PORT_BUS_KEEPER_BIT];
            // Bus-off waits for the cycle in flight; clearing takes effect at once.
            if (!bank_ctrl_q[`EXTERNAL_BUS_OFF_BIT])
                bus_off_q <= 1'b0;
            else if (state_q == ST_IDLE)
                bus_off_q <= 1'b1;
            mode_lock_q <= bus_off_q;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;
    assign addr_hit  = paddr == `WAIT_STATE_COUNTS_ADDR || paddr == `BANK_SWITCH_CONTROL_ADDR ||
                       paddr == `WAIT_STATE_CONFIG_ADDR || paddr == `BUS_STATUS_ADDR;
    assign status    = {11'h000, mode_lock_q, cur_waits_q == 4'h0 ? 1'b0 : 1'b1,
                        gen_active, bus_off_q, !acc_idle_q};

    // Ready rises one edge after setup, so every access phase is one cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h00000000;
            acc_idle_q <= 1'b0;
        end
        else
        begin
            pready     <= apb_setup;
            pslverr    <= apb_setup && !addr_hit;
            acc_idle_q <= (state_q == ST_IDLE && !take_req) && !bus_off_q &&
                          !bank_ctrl_q[`EXTERNAL_BUS_OFF_BIT];
            if (apb_setup && !pwrite)
            begin
                case (paddr)
                    `WAIT_STATE_COUNTS_ADDR:   prdata <= {16'h0000, wait_counts_q};
                    `BANK_SWITCH_CONTROL_ADDR: prdata <= {16'h0000, bank_ctrl_q};
                    `WAIT_STATE_CONFIG_ADDR:   prdata <= {16'h0000, wait_cfg_q};
                    `BUS_STATUS_ADDR:          prdata <= {16'h0000, status};
                    default:                   prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes; reserved bits are masked so they stay zero.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_counts_q <= `WAIT_STATE_COUNTS_RST;
            bank_ctrl_q   <= `BANK_SWITCH_CONTROL_RST;
            wait_cfg_q    <= `WAIT_STATE_CONFIG_RST;
        end
        else if (apb_write)
        begin
            case (paddr)
                `WAIT_STATE_COUNTS_ADDR:
                    wait_counts_q <= pwdata[15:0];
                `BANK_SWITCH_CONTROL_ADDR:
                    bank_ctrl_q <= pwdata[15:0] & `BANK_SWITCH_CONTROL_MASK;
                `WAIT_STATE_CONFIG_ADDR:
                    wait_cfg_q <= pwdata[15:0] & `WAIT_STATE_CONFIG_MASK;
                default:
                    wait_cfg_q <= wait_cfg_q;
            endcase
        end
    end
endmodule // ext_bus_wait_state_bank_switch

// ---- tb/ext_mem_model.sv ----
// A slow external memory: ready comes dly cycles into a strobe, and the bus is inverted once released.
module ext_mem_model(
    input  wire logic        pclk, ext_strobe_n_q, ext_read_q,
    input  wire logic [22:0] ext_addr_q,
    input  wire logic [7:0]  dly,
    output logic             ext_ready,
    output logic [15:0]      ext_data_in);
    timeunit 1ns;
    timeprecision 1ps;
    int c = 0;                                            // Cycles of the current strobe.
    always @(posedge pclk) c <= ext_strobe_n_q ? 0 : c + 1;
    assign ext_ready = (c >= dly);
    assign ext_data_in = (!ext_strobe_n_q && ext_read_q) ? ext_addr_q[15:0] : ~ext_addr_q[15:0];
endmodule // ext_mem_model

// ---- tb/ext_bus_wait_state_bank_switch_monitor.sv ----
// Timing relations between the register bus, the access request and the external pins.
module ext_bus_wait_state_bank_switch_monitor(
    input wire logic pclk, presetn, psel, penable, pready, pslverr, acc_req, acc_idle_q, acc_done_q,
    input wire logic ext_strobe_n_q, ext_read_q, ext_data_oe_q, ext_ready, data_keep_oe_q, mode_lock_q);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_take; acc_req && acc_idle_q; endsequence
    property p_ans; s_setup |=> pready && penable; endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_take; s_take |=> !acc_idle_q; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_done; acc_done_q |=> !acc_done_q; endproperty
    a_done: assert property (p_done) else $error("done pulse too long");
    property p_stall; !ext_strobe_n_q && !ext_ready |=> !acc_done_q; endproperty
    a_stall: assert property (p_stall) else $error("finished while not ready");
    property p_keep; data_keep_oe_q |-> !ext_data_oe_q; endproperty
    a_keep: assert property (p_keep) else $error("keeper fights driver");
    property p_off; mode_lock_q |-> ext_strobe_n_q && !ext_data_oe_q && !acc_idle_q; endproperty
    a_off: assert property (p_off) else $error("bus active while off");
    property p_wr; ext_data_oe_q |-> !ext_read_q && !ext_strobe_n_q; endproperty
    a_wr: assert property (p_wr) else $error("data driven outside write");
endmodule // ext_bus_wait_state_bank_switch_monitor
bind ext_bus_wait_state_bank_switch ext_bus_wait_state_bank_switch_monitor monitor_inst(.*);

// ---- tb/ext_bus_wait_state_bank_switch_test.sv ----
module ext_bus_wait_state_bank_switch_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, acc_req = 0, acc_read = 0, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [1:0] acc_space = '0;
    logic [22:0] acc_addr = '0, ext_addr_q;
    logic [15:0] acc_wdata = 16'h5A5A, acc_rdata_q, ext_data_out_q, ext_data_in, data_keep_q;
    logic [7:0] dly = '0;
    logic [2:0] sl = '0;
    logic pready, pslverr, acc_idle_q, acc_done_q, ext_prog_sel_n_q, ext_data_sel_n_q, ext_io_sel_n_q;
    logic ext_strobe_n_q, ext_read_q, ext_data_oe_q, ext_ready, data_keep_oe_q, host_keep_en_q, mode_lock_q;
    int num_errors = 0, n_compared = 0, b, ld, ln, l2;
    int sp[5] = '{2, 1, 1, 0, 0};
    int ad[5] = '{0, 'h8000, 0, 'h18000, 'h10000};
    int ls[5] = '{12, 9, 6, 3, 0};
    always #2.5 pclk = ~pclk;
    ext_bus_wait_state_bank_switch ext_bus_wait_state_bank_switch_inst(.*);
    ext_mem_model ext_mem_model_inst(.*);
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin num_errors++; $display("unexpected at %0t: got %h want %h", $time, g, x); end
    endtask
    // One APB transfer; the request is held until pready is seen at a rising edge.
    task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
        @(posedge pclk); penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; e = pslverr; psel <= 0; penable <= 0;
    endtask
    // One external access; ld counts cycles before the strobe, ln cycles of strobe.
    task acc(input logic [1:0] s, input logic r, input logic [22:0] a);
        do @(negedge pclk); while (acc_idle_q !== 1'b1);
        @(posedge pclk); acc_req <= 1; acc_space <= s; acc_read <= r; acc_addr <= a;
        @(posedge pclk); acc_req <= 0; ld = 0; ln = 0;
        do begin
            @(negedge pclk);
            if (ext_strobe_n_q) ld += (ln == 0);
            else begin ln++; sl = {ext_prog_sel_n_q, ext_data_sel_n_q, ext_io_sel_n_q}; end
        end
        while (acc_done_q !== 1'b1);
    endtask
    task print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000; num_errors++; $display("unexpected at %0t: timeout", $time); print_verdict;
    end
    initial
    begin
        repeat (16) @(posedge pclk); presetn <= 1; repeat (2) @(posedge pclk);
        apb(0, 12'h0A0, 0); chk(q, 32'h00007FFF);
        apb(0, 12'h0A4, 0); chk(q, 32'h0000F800);
        apb(0, 12'h0AC, 0); chk(q, 32'h00000000);
        apb(0, 12'h0FC, 0); chk(e, 1);
        apb(1, 12'h0AC, 16'hFFFF); apb(0, 12'h0AC, 0); chk(q, 32'h00000001);
        apb(1, 12'h0A4, 16'h07F8); apb(0, 12'h0A4, 0); chk(q, 32'h00000000);
        apb(1, 12'h0AC, 0); apb(1, 12'h0A0, 0); apb(0, 12'h0B0, 0); chk(q[2], 0);
        acc(1, 1, 0); b = ln;
        for (int i = 0; i < 5; i++) begin
            apb(1, 12'h0A0, 16'h0005 << ls[i]); acc(sp[i], 1, ad[i]);
            chk(ln - b, 5); chk(sl, 3'b111 ^ (3'b100 >> sp[i]));
        end
        apb(1, 12'h0A0, 16'h7FFF); apb(1, 12'h0AC, 1); acc(1, 1, 0); chk(ln - b, 14);
        apb(0, 12'h0B0, 0); chk(q[2], 1);
        apb(1, 12'h0AC, 0); apb(1, 12'h0A0, 16'h8038); acc(0, 1, 'h18000); chk(ln - b, 0);
        apb(1, 12'h0A0, 16'h8005); acc(0, 1, 'h18000); chk(ln - b, 5);
        apb(1, 12'h0A0, 0); dly <= 8; acc(1, 1, 0); l2 = ln;
        dly <= 11; acc(1, 1, 0); chk(ln - l2, 3); dly <= 0;
        $display("wait state tests done");
        apb(1, 12'h0A4, 16'hF800);
        acc(1, 1, 'h1000); acc(1, 1, 'h1000); b = ld;
        acc(1, 1, 'h2000); chk(ld - b, 1);
        acc(1, 0, 'h2000); acc(0, 1, 'h2000); chk(ld - b, 1);
        acc(1, 1, 'h2000); chk(ld - b, 1);
        apb(1, 12'h0A4, 16'hF000); acc(0, 1, 'h2000); acc(1, 1, 'h2000); chk(ld - b, 0);
        $display("bank switch tests done");
        apb(1, 12'h0A4, 16'hF806); acc(1, 1, 'h1234); repeat (2) @(negedge pclk);
        chk(data_keep_q, 'h1234); chk(data_keep_oe_q, 1); chk(host_keep_en_q, 1);
        chk(acc_rdata_q, 'h1234);
        acc(1, 0, 'h1234); repeat (2) @(negedge pclk);
        chk(data_keep_q, 'h5A5A); chk(ext_data_out_q, 'h5A5A); chk(ext_addr_q, 'h1234);
        apb(1, 12'h0A4, 16'hF801); repeat (3) @(negedge pclk);
        chk(mode_lock_q, 1); chk(acc_idle_q, 0); chk(ext_addr_q, 0);
        apb(1, 12'h0A4, 16'hF800); repeat (3) @(negedge pclk); chk(acc_idle_q, 1);
        $display("keeper and bus off tests done");
        print_verdict;
    end
endmodule // ext_bus_wait_state_bank_switch_test
